//--- rtl/irsf_map.svh
// Purpose: Shared constants of the infrared secondary flow and power block
// Assumes: 40 MHz device clock
// Notes: Cycle counts derive from the times and rates below
`ifndef IRSF_MAP_SVH
`define IRSF_MAP_SVH

`define IRSF_CLK_HZ 40000000
`define IRSF_BAUD 9600
`define IRSF_BIT_CYC (`IRSF_CLK_HZ / `IRSF_BAUD)
`define IRSF_CW 13
`define IRSF_FRAME_BITS 10
`define IRSF_IDLE_S 10
`define IRSF_IDLE_CYC (`IRSF_IDLE_S * `IRSF_CLK_HZ)
`define IRSF_HBUF_DEPTH 29
`define IRSF_CTS_LEVEL 23
`define IRSF_CTS_SLACK 6
`define IRSF_IBUF_DEPTH 64
`define IRSF_MIN_FRAME 6
`define IRSF_OVH_BYTES 8
`define IRSF_OVH_FILL 8'h00
`define IRSF_FLUSH_BITS 20
`define IRSF_INIT_CYC 16
`define IRSF_ID_LEN 10
// Arbitrary identification text, eight name characters and two revision characters
`define IRSF_ID_TEXT 80'h49_52_53_45_43_44_45_56_30_31

`endif

//--- rtl/irsf_pkg.sv
// Purpose: Types and serial helpers shared by both ends
// Assumes: Constants from irsf_map.svh
// Notes: Serial frames are start, eight data bits LSB first, stop
`include "irsf_map.svh"

package irsf_pkg;

	typedef logic [`IRSF_CW-1:0] irsf_cnt_t;

	typedef enum logic [2:0] {
		PWR_LOW = 3'h1,
		PWR_INIT = 3'h2,
		PWR_RUN = 3'h4
	} irsf_pwr_e;

	typedef enum logic [2:0] {
		LNK_POLL = 3'h1,
		LNK_DISC = 3'h2,
		LNK_CONN = 3'h4
	} irsf_link_e;

	typedef struct packed {
		logic busy;
		logic done;
		irsf_cnt_t cnt;
		logic [3:0] bitn;
		logic [7:0] sh;
	} irsf_urx_s;

	typedef struct packed {
		logic busy;
		logic line;
		irsf_cnt_t cnt;
		logic [3:0] bitn;
		logic [`IRSF_FRAME_BITS-1:0] sh;
	} irsf_utx_s;

	localparam logic [3:0] LAST_BIT = 4'(`IRSF_FRAME_BITS - 1);

	// Receiver sampling at mid bit, stop bit must be high
	function automatic irsf_urx_s irsf_urx_step(irsf_urx_s s, logic line, irsf_cnt_t bc);
		irsf_urx_s n;
		n = s;
		n.done = 1'b0;
		if (!s.busy) begin
			if (!line) begin
				n.busy = 1'b1;
				n.cnt = bc >> 1;
				n.bitn = 4'h0;
			end
		end else if (s.cnt != '0) begin
			n.cnt = s.cnt - irsf_cnt_t'(1);
		end else begin
			n.cnt = bc - irsf_cnt_t'(1);
			n.bitn = s.bitn + 4'h1;
			if (s.bitn == 4'h0 && line) begin
				n.busy = 1'b0;
			end else if (s.bitn == LAST_BIT) begin // RULE_16
				n.busy = 1'b0;
				n.done = line;
			end else begin
				n.sh = {line, s.sh[7:1]};
			end
		end
		return n;
	endfunction

	function automatic irsf_utx_s irsf_utx_load(logic [7:0] d, irsf_cnt_t bc);
		irsf_utx_s n;
		n.busy = 1'b1;
		n.line = 1'b0;
		n.cnt = bc - irsf_cnt_t'(1);
		n.bitn = 4'h0;
		n.sh = {1'b1, d, 1'b0}; // RULE_16
		return n;
	endfunction

	function automatic irsf_utx_s irsf_utx_step(irsf_utx_s s, irsf_cnt_t bc);
		irsf_utx_s n;
		n = s;
		if (s.busy) begin
			if (s.cnt != '0) begin
				n.cnt = s.cnt - irsf_cnt_t'(1);
			end else if (s.bitn == LAST_BIT) begin
				n.busy = 1'b0;
			end else begin
				n.sh = {1'b1, s.sh[`IRSF_FRAME_BITS-1:1]};
				n.bitn = s.bitn + 4'h1;
				n.cnt = bc - irsf_cnt_t'(1);
			end
		end
		n.line = n.busy ? n.sh[0] : 1'b1;
		return n;
	endfunction

endpackage

//--- rtl/irsf_if.sv
// Purpose: Host serial link between the secondary controller and its host
// Assumes: Both ends on i_clk
// Notes: Handler-active pin is open collector with an external pull-up
`timescale 1ns/100ps

interface irsf_if;
	logic host_txd;
	logic host_rxd;
	logic cts_n;
	logic rts_n;
	logic link_up;
	logic hact_o;
	logic hact_oe;
	logic handler_active_out;

	// Pull-up when the device releases the pin
	assign handler_active_out = hact_oe ? hact_o : 1'b1;

	modport dev (
		input host_txd,
		input rts_n,
		output host_rxd,
		output cts_n,
		output link_up,
		output hact_o,
		output hact_oe
	);

	modport host (
		output host_txd,
		output rts_n,
		input host_rxd,
		input cts_n,
		input link_up,
		input handler_active_out
	);
endinterface

//--- rtl/irsf_dev.sv
// Purpose: Secondary controller flow control, buffering and power state
// Assumes: Protocol stack outside supplies link events and IR bytes
// Notes: One state struct, registered once per clock
// Behaviour
// RULE_01: Photo-detect crossing reference leaves low power
// RULE_02: Reset exits low power into initialization
// RULE_03: Ten idle seconds after init return low power; code does so only from polling, another link state first drops to polling
// RULE_04: Handler-active released while handler runs, else low
// RULE_05: Link bit rate fixed, no alternative
// RULE_06: CTS high at twenty-three buffered host bytes
// RULE_07: Host receive block is twenty-nine bytes
// RULE_08: IR receive block is sixty-four bytes
// RULE_09: Primary frames at least six bytes long
// RULE_10: Eight overhead bytes accompany each packet
// RULE_11: Host stops sending while CTS high
// RULE_12: IR transmit gated off during reception
// RULE_13: One bit gap between receive and transmit
// RULE_14: Fixed identification text with revision suffix
// RULE_15: Polling, then discovery, then connected exchange
// RULE_16: Host serial byte is ten bit periods
// RULE_17: Six more host bytes accepted after CTS
// RULE_18: Host RTS low to receive, else timeout
// RULE_19: CTS low only after host buffer drained
`timescale 1ns/100ps
`include "irsf_map.svh"

module irsf_dev #(
	parameter int BIT_CYC = `IRSF_BIT_CYC,
	parameter int IDLE_CYC = `IRSF_IDLE_CYC,
	parameter int HB = `IRSF_HBUF_DEPTH,
	parameter int IB = `IRSF_IBUF_DEPTH,
	parameter logic [8*`IRSF_ID_LEN-1:0] ID_TEXT = `IRSF_ID_TEXT
) (
	input wire logic i_clk,
	input wire logic i_srst,
	irsf_if.dev lnk,
	input wire logic [7:0] i_photo_detect_in,
	input wire logic [7:0] i_photo_detect_reference,
	input wire logic i_ir_receive_in,
	input wire logic i_ir_rx_valid,
	input wire logic [7:0] i_ir_rx_data,
	input wire logic i_ir_rx_end,
	input wire logic i_ir_tx_ready,
	input wire logic i_disc_start,
	input wire logic i_disc_done,
	input wire logic i_link_close,
	input wire logic i_id_request,
	output logic o_ir_tx_valid,
	output logic [7:0] o_ir_tx_data,
	output logic o_ir_tx_last,
	output logic o_osc_enable,
	output irsf_pkg::irsf_link_e o_link_state
);
	localparam int HW = $clog2(HB + 1);
	localparam int IW = $clog2(IB + 1);
	localparam irsf_pkg::irsf_cnt_t BC = irsf_pkg::irsf_cnt_t'(BIT_CYC); // RULE_05
	localparam logic [31:0] IDLE_L = 32'(IDLE_CYC - 1);
	localparam logic [31:0] FLUSH_L = 32'(`IRSF_FLUSH_BITS * BIT_CYC);
	localparam logic [15:0] TA_L = 16'(BIT_CYC);
	localparam logic [7:0] OVH = 8'(`IRSF_OVH_BYTES);
	localparam logic [7:0] ID_LEN = 8'(`IRSF_ID_LEN);
	localparam logic [7:0] MINF = 8'(`IRSF_MIN_FRAME);
	localparam logic [HW-1:0] HB_L = HW'(HB);
	localparam logic [HW-1:0] CTS_L = HW'(`IRSF_CTS_LEVEL);
	localparam logic [IW-1:0] IB_L = IW'(IB);
	localparam logic [4:0] INIT_L = 5'(`IRSF_INIT_CYC - 1);

	typedef struct packed {
		irsf_pkg::irsf_pwr_e pwr;
		irsf_pkg::irsf_link_e lnk;
		logic osc;
		logic hact_oe;
		logic up;
		logic pd_above;
		logic [4:0] init_cnt;
		logic [31:0] idle;
		logic [31:0] rto;
		logic [31:0] hgap;
		logic [15:0] ta;
		irsf_pkg::irsf_urx_s hrx;
		irsf_pkg::irsf_utx_s htx;
		logic [HB-1:0][7:0] hbuf;
		logic [HW-1:0] hcnt;
		logic cts;
		logic [IB-1:0][7:0] ibuf;
		logic [IW-1:0] icnt;
		logic [IW-1:0] iwr;
		logic [7:0] fcnt;
		logic tx_on;
		logic tx_id;
		logic id_pend;
		logic [7:0] tx_idx;
		logic [7:0] tx_len;
		logic tx_valid;
		logic tx_last;
		logic [7:0] tx_data;
	} irsf_dev_s;

	irsf_dev_s q;
	irsf_dev_s n;

	always_comb begin
		logic [7:0] k;
		logic run;
		n = q;
		k = '0;
		run = (q.pwr == irsf_pkg::PWR_RUN);
		n.hrx = irsf_pkg::irsf_urx_step(q.hrx, lnk.host_txd, BC);
		n.htx = irsf_pkg::irsf_utx_step(q.htx, BC);
		n.ta = (q.ta != '0) ? q.ta - 16'h1 : q.ta;
		n.hgap = (q.hgap != FLUSH_L) ? q.hgap + 32'h1 : q.hgap;
		n.tx_valid = 1'b0;
		n.pd_above = i_photo_detect_in > i_photo_detect_reference;
		case (q.pwr)
			irsf_pkg::PWR_LOW: begin
				if (n.pd_above && !q.pd_above) begin // RULE_01
					n.pwr = irsf_pkg::PWR_INIT;
					n.osc = 1'b1;
					n.init_cnt = '0;
				end
			end
			irsf_pkg::PWR_INIT: begin
				n.init_cnt = q.init_cnt + 5'h1;
				n.idle = '0;
				if (q.init_cnt == INIT_L) begin
					n.pwr = irsf_pkg::PWR_RUN;
					n.hact_oe = 1'b0; // RULE_04
				end
			end
			irsf_pkg::PWR_RUN: begin
				if (i_ir_receive_in || i_ir_rx_valid) begin
					n.idle = '0;
				end else if (q.idle == IDLE_L) begin
					n.idle = '0;
					if (q.lnk == irsf_pkg::LNK_POLL) begin // RULE_03
						n.pwr = irsf_pkg::PWR_LOW;
						n.osc = 1'b0;
						n.hact_oe = 1'b1; // RULE_04
					end else begin
						n.lnk = irsf_pkg::LNK_POLL;
					end
				end else begin
					n.idle = q.idle + 32'h1;
				end
			end
			default: begin
				n.pwr = irsf_pkg::PWR_INIT;
			end
		endcase
		if (run) begin
			if (i_link_close) begin // RULE_15
				n.lnk = irsf_pkg::LNK_POLL;
			end else if (i_disc_start && q.lnk == irsf_pkg::LNK_POLL) begin
				n.lnk = irsf_pkg::LNK_DISC;
			end else if (i_disc_done && q.lnk == irsf_pkg::LNK_DISC) begin
				n.lnk = irsf_pkg::LNK_CONN;
			end
			if (i_id_request) begin
				n.id_pend = 1'b1;
			end
		end
		// IR frame transmit progress
		if (q.tx_valid && i_ir_tx_ready) begin
			n.tx_idx = q.tx_idx + 8'h1;
			if (q.tx_last) begin
				n.tx_on = 1'b0;
				if (!q.tx_id) begin
					n.hbuf = q.hbuf >> (8 * int'(q.tx_len));
					n.hcnt = q.hcnt - HW'(q.tx_len);
				end
			end
		end
		// Host serial bytes into the host buffer
		if (n.hrx.done) begin
			n.hgap = '0;
			if (n.hcnt < HB_L) begin // RULE_07 RULE_17
				n.hbuf[n.hcnt] = n.hrx.sh;
				n.hcnt = n.hcnt + HW'(1);
			end
		end
		// Frame start, identification first
		if (!n.tx_on && run) begin
			n.tx_idx = '0;
			if (q.id_pend) begin // RULE_14
				n.tx_on = 1'b1;
				n.tx_id = 1'b1;
				n.tx_len = ID_LEN;
				n.id_pend = i_id_request;
			end else if (q.lnk == irsf_pkg::LNK_CONN && n.hcnt != '0 &&
				(n.hcnt >= CTS_L || n.hgap == FLUSH_L)) begin
				n.tx_on = 1'b1;
				n.tx_id = 1'b0;
				n.tx_len = 8'(n.hcnt);
			end
		end
		if (n.tx_on && !i_ir_receive_in && !i_ir_rx_valid && q.ta == '0) begin // RULE_12 RULE_13
			n.tx_valid = 1'b1;
			n.tx_last = (n.tx_idx == n.tx_len + OVH - 8'h1); // RULE_10
			k = n.tx_idx - OVH;
			if (n.tx_idx < OVH) begin
				n.tx_data = `IRSF_OVH_FILL;
			end else if (n.tx_id) begin
				n.tx_data = ID_TEXT[8 * (`IRSF_ID_LEN - 1 - int'(k)) +: 8];
			end else begin
				n.tx_data = q.hbuf[k];
			end
		end
		// IR payload toward the host while RTS is low
		if (run && !q.htx.busy && !lnk.rts_n && q.icnt != '0) begin // RULE_18
			n.htx = irsf_pkg::irsf_utx_load(q.ibuf[0], BC);
			n.ibuf = q.ibuf >> 8;
			n.icnt = q.icnt - IW'(1);
			n.iwr = q.iwr - IW'(1);
		end
		if (q.icnt != '0 && lnk.rts_n) begin
			n.rto = q.rto + 32'h1;
			if (q.rto == IDLE_L) begin // RULE_18
				n.lnk = irsf_pkg::LNK_POLL;
				n.icnt = '0;
				n.iwr = '0;
				n.rto = '0;
			end
		end else begin
			n.rto = '0;
		end
		// IR frames from the primary
		if (run && i_ir_rx_valid) begin
			n.ta = TA_L; // RULE_13
			if (q.fcnt != 8'hFF) begin
				n.fcnt = q.fcnt + 8'h1;
			end
			if (q.fcnt >= OVH && n.iwr < IB_L) begin // RULE_08
				n.ibuf[n.iwr] = i_ir_rx_data;
				n.iwr = n.iwr + IW'(1);
			end
		end
		if (i_ir_rx_end) begin
			n.fcnt = '0;
			if (q.fcnt >= MINF) begin // RULE_09
				n.icnt = n.iwr;
			end else begin
				n.iwr = n.icnt;
			end
		end
		n.up = (n.lnk == irsf_pkg::LNK_CONN);
		n.cts = !n.up || n.hcnt >= CTS_L || (q.cts && n.hcnt != '0); // RULE_06 RULE_11 RULE_19
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			q <= '0;
			q.pwr <= irsf_pkg::PWR_INIT; // RULE_02
			q.lnk <= irsf_pkg::LNK_POLL;
			q.osc <= 1'b1;
			q.hact_oe <= 1'b1;
			q.cts <= 1'b1;
			q.htx.line <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign lnk.host_rxd = q.htx.line;
	assign lnk.cts_n = q.cts;
	assign lnk.link_up = q.up;
	assign lnk.hact_o = 1'b0;
	assign lnk.hact_oe = q.hact_oe;
	assign o_ir_tx_valid = q.tx_valid;
	assign o_ir_tx_data = q.tx_data;
	assign o_ir_tx_last = q.tx_last;
	assign o_osc_enable = q.osc;
	assign o_link_state = q.lnk;
endmodule

//--- rtl/irsf_host.sv
// Purpose: Host controller UART end with hardware handshake
// Assumes: Same bit rate as the device serial port
// Notes: Starts a byte only while CTS is low
`timescale 1ns/100ps
`include "irsf_map.svh"

module irsf_host #(
	parameter int BIT_CYC = `IRSF_BIT_CYC
) (
	input wire logic i_clk,
	input wire logic i_srst,
	irsf_if.host lnk,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_ready,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	input wire logic i_rx_hold,
	output logic o_link_up,
	output logic o_handler_active
);
	localparam irsf_pkg::irsf_cnt_t BC = irsf_pkg::irsf_cnt_t'(BIT_CYC);

	typedef struct packed {
		irsf_pkg::irsf_urx_s urx;
		irsf_pkg::irsf_utx_s utx;
		logic rts_n;
		logic tx_ready;
		logic rx_valid;
		logic [7:0] rx_data;
		logic up;
		logic hact;
	} irsf_host_s;

	irsf_host_s q;
	irsf_host_s n;

	always_comb begin
		n = q;
		n.urx = irsf_pkg::irsf_urx_step(q.urx, lnk.host_rxd, BC);
		n.utx = irsf_pkg::irsf_utx_step(q.utx, BC);
		if (i_tx_valid && q.tx_ready) begin
			n.utx = irsf_pkg::irsf_utx_load(i_tx_data, BC);
		end
		n.tx_ready = !n.utx.busy && !lnk.cts_n; // RULE_11
		n.rx_valid = n.urx.done;
		if (n.urx.done) begin
			n.rx_data = n.urx.sh;
		end
		n.rts_n = i_rx_hold; // RULE_18
		n.up = lnk.link_up;
		n.hact = lnk.handler_active_out;
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			q <= '0;
			q.utx.line <= 1'b1;
			q.rts_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign lnk.host_txd = q.utx.line;
	assign lnk.rts_n = q.rts_n;
	assign o_tx_ready = q.tx_ready;
	assign o_rx_valid = q.rx_valid;
	assign o_rx_data = q.rx_data;
	assign o_link_up = q.up;
	assign o_handler_active = q.hact;
endmodule

//--- tb/irsf_asserts.sv
// Purpose: Interface checks for the host serial link
// Assumes: One clock, sync reset
// Notes: Sees interface signals only
`timescale 1ns/100ps

module irsf_asserts #(
	parameter int BIT_CYC = 16
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic host_txd,
	input wire logic host_rxd,
	input wire logic cts_n,
	input wire logic link_up,
	input wire logic hact_o,
	input wire logic hact_oe
);
	logic [15:0] rx_low_reg;
	logic [15:0] tx_low_reg;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);

	// Length of the current low run on each line
	always_ff @(posedge i_clk) begin
		rx_low_reg <= (i_srst || host_rxd) ? 16'h0000 : rx_low_reg + 16'h0001;
		tx_low_reg <= (i_srst || host_txd) ? 16'h0000 : tx_low_reg + 16'h0001;
	end

	sequence s_rel;
		$fell(i_srst);
	endsequence
	sequence s_init;
		hact_oe [*8] ##1 hact_oe [*6] ##[1:6] !hact_oe;
	endsequence

	property p_rst_out;
		s_rel |-> cts_n && !link_up && host_rxd && hact_oe;
	endproperty
	property p_init;
		s_rel |-> s_init;
	endproperty
	property p_hact_low;
		hact_oe |-> !hact_o && !link_up;
	endproperty
	property p_cts_conn;
		!link_up ##1 !link_up |-> cts_n;
	endproperty
	property p_rx_bits;
		$rose(host_rxd) |-> rx_low_reg != 16'h0000 && rx_low_reg % BIT_CYC == 0;
	endproperty
	property p_tx_bits;
		$rose(host_txd) |-> tx_low_reg != 16'h0000 && tx_low_reg % BIT_CYC == 0;
	endproperty
	property p_tx_cts;
		$fell(host_txd) |-> !$past(cts_n, 2);
	endproperty
	property p_cts_hold;
		$rose(cts_n) && link_up |-> cts_n [*8];
	endproperty

	a_rst_out: assert property (p_rst_out) else $error("outputs after reset");
	a_init: assert property (p_init) else $error("init length");
	a_hact_low: assert property (p_hact_low) else $error("pin not low");
	a_cts_conn: assert property (p_cts_conn) else $error("cts low unconnected");
	a_rx_bits: assert property (p_rx_bits) else $error("rx bit length");
	a_tx_bits: assert property (p_tx_bits) else $error("tx bit length");
	a_tx_cts: assert property (p_tx_cts) else $error("sent while cts high");
	a_cts_hold: assert property (p_cts_hold) else $error("cts fell early");
endmodule

//--- tb/irsf_tb.sv
// Purpose: Bench for both ends of the host serial link
// Assumes: Short bit time and idle count
// Notes: Random data from seed 40
`timescale 1ns/100ps

module irsf_tb;
	localparam int BC = 16;
	// Arbitrary identification text
	localparam logic [79:0] IDT = 80'h54_45_53_54_55_4E_49_54_41_42;
	logic clk, srst = 1'b1, rin = 1'b0, rxv = 1'b0, rxe = 1'b0, txr = 1'b1;
	logic ds = 1'b0, dd = 1'b0, lc = 1'b0, idr = 1'b0, tv = 1'b0, hold = 1'b0, keep = 1'b1;
	logic [7:0] pdi = 8'h00, pdr = 8'h80, rxd = 8'h00, td = 8'h00;
	logic irv, irl, osc, tr, hrv, lu, ha, rin_prev = 1'b0;
	logic [7:0] irb, hrd;
	irsf_pkg::irsf_link_e st;
	logic [7:0] exp_q[$], hq[$], rq[$];
	int fq[$];
	int errors = 0, cmp_count = 0, cyc = 0, last_rx = -1000, ovh = 0, pay = 0;

	irsf_if lnk();
	irsf_dev #(.BIT_CYC(BC), .IDLE_CYC(2000), .ID_TEXT(IDT)) i_irsf_dev (
		.i_clk(clk), .i_srst(srst), .lnk(lnk), .i_photo_detect_in(pdi),
		.i_photo_detect_reference(pdr), .i_ir_receive_in(rin), .i_ir_rx_valid(rxv),
		.i_ir_rx_data(rxd), .i_ir_rx_end(rxe), .i_ir_tx_ready(txr), .i_disc_start(ds),
		.i_disc_done(dd), .i_link_close(lc), .i_id_request(idr), .o_ir_tx_valid(irv),
		.o_ir_tx_data(irb), .o_ir_tx_last(irl), .o_osc_enable(osc), .o_link_state(st));
	irsf_host #(.BIT_CYC(BC)) i_irsf_host (.i_clk(clk), .i_srst(srst), .lnk(lnk),
		.i_tx_valid(tv), .i_tx_data(td), .o_tx_ready(tr), .o_rx_valid(hrv),
		.o_rx_data(hrd), .i_rx_hold(hold), .o_link_up(lu), .o_handler_active(ha));
	irsf_asserts #(.BIT_CYC(BC)) i_irsf_asserts (.i_clk(clk), .i_srst(srst),
		.host_txd(lnk.host_txd), .host_rxd(lnk.host_rxd), .cts_n(lnk.cts_n),
		.link_up(lnk.link_up), .hact_o(lnk.hact_o), .hact_oe(lnk.hact_oe));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic stc(input irsf_pkg::irsf_link_e e);
		chk(8'(st), 8'(e), "state");
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	// Holds valid between bytes; caller drops it
	task automatic hsend(input logic [7:0] d);
		tv = 1'b1;
		td = d;
		exp_q.push_back(d);
		while (tr !== 1'b1) tick(1);
		tick(1);
	endtask
	task automatic irframe(input int n);
		for (int i = 0; i < n; i++) begin
			rxd = 8'($urandom);
			if (i >= 8) hq.push_back(rxd);
			pulse(rxv);
			tick(1);
		end
		pulse(rxe);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Stalling encoder and periodic link traffic
	always @(negedge clk) begin
		txr <= 1'($urandom_range(1));
		rin <= keep && (cyc % 400 == 399);
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		rin_prev <= rin;
		if (rxv === 1'b1) last_rx <= cyc;
		if (hrv === 1'b1) rq.push_back(hrd);
		if (irv === 1'b1) begin
			chk(8'(rin_prev), 8'h00, "tx in rx");
			chk(8'(cyc - last_rx >= BC), 8'h01, "gap");
			if (txr) begin
				if (ovh < 8) begin
					chk(irb, 8'h00, "ovh");
					ovh++;
				end else begin
					chk(irb, exp_q.pop_front(), "data");
					pay++;
				end
				if (irl === 1'b1) begin
					fq.push_back(pay);
					ovh = 0;
					pay = 0;
				end
			end
		end
		if (cyc == 40000) begin
			errors++;
			test_done();
		end
	end

	initial begin
		void'($urandom(40));
		tick(4);
		srst = 1'b0;
		tick(1);
		chk(8'(osc), 8'h01, "osc");
		stc(irsf_pkg::LNK_POLL);
		tick(20);
		pulse(ds);
		stc(irsf_pkg::LNK_DISC);
		pulse(lc);
		stc(irsf_pkg::LNK_POLL);
		pulse(ds);
		pulse(dd);
		tick(2);
		stc(irsf_pkg::LNK_CONN);
		chk(8'(lu), 8'h01, "up");
		$display("link test end");
		for (int i = 0; i < 30; i++) hsend(8'($urandom));
		tv = 1'b0;
		tick(1000);
		chk(8'(fq.size()), 8'h02, "frames");
		chk(8'(fq[0]), 8'h17, "cts level");
		chk(8'(fq[1]), 8'h07, "rest");
		$display("host test end");
		fq.delete();
		for (int i = 9; i >= 0; i--) exp_q.push_back(IDT[i*8 +: 8]);
		pulse(idr);
		irframe(6);
		tick(200);
		chk(8'(fq.size()), 8'h01, "id");
		chk(8'(fq[0]), 8'h0A, "id len");
		$display("id test end");
		irframe(72);
		while (rq.size() < 64) tick(1);
		tick(200);
		chk(8'(rq.size()), 8'h40, "rx cnt");
		foreach (hq[i]) chk(rq[i], hq[i], "rx");
		$display("ir test end");
		hold = 1'b1;
		irframe(9);
		tick(2300);
		stc(irsf_pkg::LNK_POLL);
		hold = 1'b0;
		tick(300);
		chk(8'(rq.size()), 8'h40, "flush");
		$display("rts test end");
		keep = 1'b0;
		tick(2200);
		chk(8'(osc), 8'h00, "sleep");
		chk(8'(ha), 8'h00, "pin");
		pdi = 8'hC0;
		tick(3);
		chk(8'(osc), 8'h01, "wake");
		tick(30);
		chk(8'(ha), 8'h01, "active");
		$display("power test end");
		test_done();
	end
endmodule
